// ==== logic/gcr_cfg.svh ====
// Constants for the global configuration register bank.
// Included by the package and the bank; holds definitions only.
`ifndef GCR_CFG_SVH
`define GCR_CFG_SVH
`define GCR_IDX_CFG_CTRL   8'h02
`define GCR_IDX_RUN_SEL    8'h03
`define GCR_IDX_LDN        8'h07
`define GCR_IDX_DEV_ID     8'h20
`define GCR_IDX_DEV_REV    8'h21
`define GCR_IDX_PWR_EN     8'h22
`define GCR_IDX_PWR_MGMT   8'h23
`define GCR_IDX_OSC        8'h24
`define GCR_RST_CFG_CTRL   8'h00
`define GCR_RST_RUN_SEL    8'h03
`define GCR_RST_LDN        8'h00
`define GCR_RST_PWR_EN     8'h00
`define GCR_RST_PWR_MGMT   8'h00
`define GCR_RST_OSC        8'h04
`define GCR_MASK_RUN_SEL   8'h83
`define GCR_MASK_PWR       8'h39
`define GCR_MASK_OSC       8'h8E
`define GCR_BIT_SOFT_RST   0
`define GCR_BIT_RUN_EN     7
`define GCR_BIT_PLL_OFF    1
`define GCR_BIT_IRQ8_POL   7
`define GCR_BIT_FDC        0
`define GCR_BIT_PAR        3
`define GCR_BIT_SER1       4
`define GCR_BIT_SER2       5
`define GCR_OSC_LO         2
`define GCR_OSC_HI         3
`define GCR_OSC_STOP       2'h3
`define GCR_RUN_ADDR_00    8'hE0
`define GCR_RUN_ADDR_01    8'hE2
`define GCR_RUN_ADDR_10    8'hE4
`define GCR_RUN_ADDR_11    8'hEA
`define GCR_ZERO           8'h00
`endif

// ==== logic/gcr_pkg.sv ====
// Types shared by the global configuration register bank.
// Assumes gcr_cfg.svh is on the include path.
`include "gcr_cfg.svh"
package gcr_pkg;
  // Per-function enables, one bit each
  typedef struct packed {
    logic ser2;
    logic ser1;
    logic par;
    logic fdc;
  } gcr_func_s;
  // Clocking controls decoded from the oscillator register
  typedef struct packed {
    logic osc_run;
    logic baud_clk_en;
    logic pll_off;
    logic irq8_active_low;
  } gcr_clk_s;
endpackage : gcr_pkg

// ==== logic/gcr_bank.sv ====
// Global configuration register bank, indices 0x00-0x2F, index/data port access.
// Assumes host strobes are synchronous one-cycle pulses and cfg_mode comes from
// the configuration-entry logic outside this block.
`timescale 1ns/1ps
`include "gcr_cfg.svh"
module gcr_bank #(
  parameter logic [7:0] DEV_ID  = 8'h5A, // Arbitrary value
  parameter logic [7:0] DEV_REV = 8'h01  // Arbitrary value
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             cfg_mode,
  input  wire logic             index_wr,
  input  wire logic             data_wr,
  input  wire logic             data_rd,
  input  wire logic [7:0]       wdata,
  output logic      [7:0]       rdata,
  output logic      [7:0]       index,
  output logic                  soft_reset,
  output logic                  run_access_en,
  output logic      [7:0]       run_sel_addr,
  output logic      [7:0]       logical_device,
  output gcr_pkg::gcr_func_s    power_enable,
  output gcr_pkg::gcr_func_s    auto_power,
  output gcr_pkg::gcr_clk_s     clock_ctrl
);
  import gcr_pkg::*;

  logic [7:0] run_mode_access_select;
  logic [7:0] logical_device_select;
  logic [7:0] function_power_enable;
  logic [7:0] auto_power_management;
  logic [7:0] oscillator_control;
  logic       wr_ok;
  logic       rd_ok;
  logic       soft_hit;
  logic [7:0] next_rdata;

  // Accesses outside configuration mode are dropped
  assign wr_ok = data_wr && cfg_mode;
  assign rd_ok = data_rd && cfg_mode;
  // Only bit 0 of the control write means anything; the register reads zero
  assign soft_hit = wr_ok && (index == `GCR_IDX_CFG_CTRL) && wdata[`GCR_BIT_SOFT_RST];

  // Index latch, full eight bits kept so upper indices never alias
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      index <= `GCR_ZERO;
    end else if (index_wr && cfg_mode) begin
      index <= wdata;
    end
  end

  // Soft reset is a one-cycle pulse, nothing stored to clear later
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      soft_reset <= 1'b0;
    end else begin
      soft_reset <= soft_hit;
    end
  end

  // Global registers hold their values across soft reset: none defines one here
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      run_mode_access_select <= `GCR_RST_RUN_SEL;
      logical_device_select  <= `GCR_RST_LDN;
      function_power_enable  <= `GCR_RST_PWR_EN;
      auto_power_management  <= `GCR_RST_PWR_MGMT;
      oscillator_control     <= `GCR_RST_OSC;
    end else if (wr_ok) begin
      // Exact compares on the full index
      if (index == `GCR_IDX_RUN_SEL) begin
        run_mode_access_select <= wdata & `GCR_MASK_RUN_SEL;
      end else if (index == `GCR_IDX_LDN) begin
        logical_device_select <= wdata;
      end else if (index == `GCR_IDX_PWR_EN) begin
        function_power_enable <= wdata & `GCR_MASK_PWR;
      end else if (index == `GCR_IDX_PWR_MGMT) begin
        auto_power_management <= wdata & `GCR_MASK_PWR;
      end else if (index == `GCR_IDX_OSC) begin
        // Bits 6:4 and bit 0 dropped whatever software writes there
        oscillator_control <= wdata & `GCR_MASK_OSC;
      end
    end
  end

  // Read mux; every other index returns zero
  always_comb begin
    next_rdata = `GCR_ZERO;
    if (index == `GCR_IDX_RUN_SEL) begin
      next_rdata = run_mode_access_select;
    end else if (index == `GCR_IDX_LDN) begin
      next_rdata = logical_device_select;
    end else if (index == `GCR_IDX_DEV_ID) begin
      next_rdata = DEV_ID;
    end else if (index == `GCR_IDX_DEV_REV) begin
      next_rdata = DEV_REV;
    end else if (index == `GCR_IDX_PWR_EN) begin
      next_rdata = function_power_enable;
    end else if (index == `GCR_IDX_PWR_MGMT) begin
      next_rdata = auto_power_management;
    end else if (index == `GCR_IDX_OSC) begin
      next_rdata = oscillator_control;
    end
  end

  // Read data holds until the next permitted read
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rdata <= `GCR_ZERO;
    end else if (rd_ok) begin
      rdata <= next_rdata;
    end
  end

  // Registered decode of controls toward the rest of the chip
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      run_access_en  <= 1'b0;
      run_sel_addr   <= `GCR_RUN_ADDR_11;
      logical_device <= `GCR_RST_LDN;
      power_enable   <= '0;
      auto_power     <= '0;
      clock_ctrl     <= '{osc_run: 1'b1, baud_clk_en: 1'b1, pll_off: 1'b0,
                          irq8_active_low: 1'b0};
    end else begin
      run_access_en <= run_mode_access_select[`GCR_BIT_RUN_EN];
      case (run_mode_access_select[1:0])
        2'h0:    run_sel_addr <= `GCR_RUN_ADDR_00;
        2'h1:    run_sel_addr <= `GCR_RUN_ADDR_01;
        2'h2:    run_sel_addr <= `GCR_RUN_ADDR_10;
        default: run_sel_addr <= `GCR_RUN_ADDR_11;
      endcase
      logical_device <= logical_device_select;
      power_enable <= '{ser2: function_power_enable[`GCR_BIT_SER2],
                        ser1: function_power_enable[`GCR_BIT_SER1],
                        par:  function_power_enable[`GCR_BIT_PAR],
                        fdc:  function_power_enable[`GCR_BIT_FDC]};
      auto_power <= '{ser2: auto_power_management[`GCR_BIT_SER2],
                      ser1: auto_power_management[`GCR_BIT_SER1],
                      par:  auto_power_management[`GCR_BIT_PAR],
                      fdc:  auto_power_management[`GCR_BIT_FDC]};
      clock_ctrl.osc_run <=
        oscillator_control[`GCR_OSC_HI:`GCR_OSC_LO] != `GCR_OSC_STOP;
      clock_ctrl.baud_clk_en <=
        oscillator_control[`GCR_OSC_HI:`GCR_OSC_LO] != `GCR_OSC_STOP;
      clock_ctrl.pll_off <= oscillator_control[`GCR_BIT_PLL_OFF];
      clock_ctrl.irq8_active_low <= oscillator_control[`GCR_BIT_IRQ8_POL];
    end
  end
endmodule : gcr_bank

// ==== verification/gcr_checker.sv ====
// Port checker for the global configuration register bank.
// Bound to gcr_bank; sees only its ports, one clock domain.
`timescale 1ns/1ps
module gcr_checker #(
  parameter logic [7:0] DEV_ID  = 8'h5A,
  parameter logic [7:0] DEV_REV = 8'h01
) (
  input wire logic              clock, rst_b, cfg_mode,
  input wire logic              index_wr, data_wr, data_rd, soft_reset,
  input wire logic [7:0]        wdata, rdata, index, run_sel_addr,
  input wire gcr_pkg::gcr_clk_s clock_ctrl
);
  import gcr_pkg::*;
  logic rd;
  logic wr;
  // Strobes count only inside configuration mode
  assign rd = data_rd && cfg_mode;
  assign wr = data_wr && cfg_mode;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_soft_cause: assert property (wr && index == 8'h02 && wdata[0] |=> soft_reset)
    else $error("soft reset missed");
  a_soft_clear: assert property (soft_reset |=> !soft_reset)
    else $error("soft reset stuck");
  a_index_load: assert property (index_wr && cfg_mode |=> index == $past(wdata))
    else $error("index not loaded");
  a_index_keep: assert property (!(index_wr && cfg_mode) |=> $stable(index))
    else $error("index moved");
  a_rd_zero: assert property (rd && index > 8'h24 |=> rdata == 8'h00)
    else $error("reserved read not zero");
  a_rd_ident: assert property (rd && index == 8'h20 |=> rdata == DEV_ID)
    else $error("bad ident");
  a_rdata_keep: assert property (!rd |=> $stable(rdata))
    else $error("rdata moved");
  a_mgmt_top: assert property (rd && index == 8'h23 |=> rdata[7:6] == 2'h0)
    else $error("mgmt top bits set");
  a_osc_pair: assert property (clock_ctrl.osc_run == clock_ctrl.baud_clk_en)
    else $error("osc and baud split");
endmodule : gcr_checker

// ==== verification/gcr_host.sv ====
// Host model driving the index and data ports.
// Strobes change 1 ns after the rising clock edge.
`timescale 1ns/1ps
module gcr_host (
  input  wire logic       clock,
  input  wire logic [7:0] rdata,
  output logic            index_wr, data_wr, data_rd,
  output logic      [7:0] wdata
);
  initial {index_wr, data_wr, data_rd, wdata} = 11'h000;
  // Index first, then one data access; released data is inverted
  task automatic acc(input logic w, input logic [7:0] i, d, output logic [7:0] q);
    {index_wr, wdata} = {1'h1, i};
    @(posedge clock) #1;
    {index_wr, data_wr, data_rd, wdata} = {1'h0, w, !w, d};
    @(posedge clock) #1;
    {data_wr, data_rd, wdata, q} = {2'h0, ~d, rdata};
  endtask : acc
endmodule : gcr_host

// ==== verification/gcr_bank_tb.sv ====
// Testbench for the global configuration register bank.
// Host model drives the ports; checker bound at the foot.
`timescale 1ns/1ps
module gcr_bank_tb;
  import gcr_pkg::*;
  logic       clock = 1'h0, rst_b = 1'h0, cfg_mode = 1'h1;
  logic       index_wr, data_wr, data_rd, soft_reset, run_access_en;
  logic [7:0] wdata, rdata, index, run_sel_addr, logical_device, q;
  gcr_func_s  power_enable, auto_power;
  gcr_clk_s   clock_ctrl;
  int         n_fail = 0, samples_checked = 0, n_cyc = 0;
  // Ident values are arbitrary
  gcr_bank #(.DEV_ID(8'h3C), .DEV_REV(8'h07)) i_gcr_bank (.*);
  gcr_host i_gcr_host (.*);
  always #5 clock = ~clock;
  // Hang guard, far above the roughly 70 cycles used
  always @(posedge clock) begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == 3000) begin
      n_fail++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test
  // Extra edge lets derived outputs settle
  task automatic wr(input logic [7:0] i, d);
    i_gcr_host.acc(1'h1, i, d, q);
    @(posedge clock) #1;
  endtask : wr
  task automatic rd(input logic [7:0] i, e);
    i_gcr_host.acc(1'h0, i, 8'h00, q);
    chk(q, e);
  endtask : rd
  task automatic t_defaults();
    rd(8'h03, 8'h03);
    rd(8'h24, 8'h04);
    rd(8'h20, 8'h3C);
    rd(8'h21, 8'h07);
    rd(8'h02, 8'h00);
    chk(run_sel_addr, 8'hEA);
    chk({4'h0, clock_ctrl}, 8'h0C);
  endtask : t_defaults
  task automatic t_masks();
    wr(8'h22, 8'hF1);
    rd(8'h22, 8'h31);
    chk({4'h0, power_enable}, 8'h0D);
    wr(8'h23, 8'hC8);
    wr(8'hA3, 8'hFF);
    rd(8'h23, 8'h08);
    chk({4'h0, auto_power}, 8'h02);
    rd(8'hA3, 8'h00);
    wr(8'h20, 8'hFF);
    rd(8'h20, 8'h3C);
  endtask : t_masks
  task automatic t_osc();
    wr(8'h24, 8'h8E);
    chk({4'h0, clock_ctrl}, 8'h03);
    rd(8'h24, 8'h8E);
    wr(8'h24, 8'h08);
    chk({4'h0, clock_ctrl}, 8'h0C);
  endtask : t_osc
  task automatic t_run();
    logic [7:0] addr [4] = '{8'hE0, 8'hE2, 8'hE4, 8'hEA};
    for (int k = 0; k < 4; k++) begin
      wr(8'h03, {k[0], 5'h00, k[1:0]});
      chk(run_sel_addr, addr[k]);
      chk({7'h00, run_access_en}, {7'h00, k[0]});
    end
    wr(8'h07, 8'h05);
    chk(logical_device, 8'h05);
  endtask : t_run
  task automatic t_cfg_soft();
    cfg_mode = 1'h0;
    i_gcr_host.acc(1'h1, 8'h22, 8'h00, q);
    cfg_mode = 1'h1;
    chk(index, 8'h07);
    rd(8'h07, 8'h05);
    i_gcr_host.acc(1'h1, 8'h02, 8'h01, q);
    chk({7'h00, soft_reset}, 8'h01);
    @(posedge clock) #1;
    chk({7'h00, soft_reset}, 8'h00);
    rd(8'h22, 8'h31);
  endtask : t_cfg_soft
  initial begin
    repeat (8) @(posedge clock);
    #1 rst_b = 1'h1;
    t_defaults();
    t_masks();
    t_osc();
    t_run();
    t_cfg_soft();
    stop_test();
  end
endmodule : gcr_bank_tb
bind gcr_bank gcr_checker #(.DEV_ID(DEV_ID), .DEV_REV(DEV_REV)) i_gcr_checker (.*);
